// ### ctl_model.sv
// test controller model driving tck, tms and tdi
// assumes a 25 MHz clock; tck idles high between frames
`timescale 1ns/1ps
module ctl_model (
  input wire logic clock,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one 320 ns period: fall, 5 clocks low, sample tdo, rise, 3 clocks high
  task automatic cyc(input logic m, input logic d, output logic o);
    @(posedge clock);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (5) @(posedge clock);
    o = tdo;
    tck <= 1'b1;
    repeat (2) @(posedge clock);
  endtask
  // from idle: shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [89:0] din,
    output logic [89:0] dout);
    logic o;
    dout = '0;
    cyc(1'b1, 1'b0, o);
    if (ir) cyc(1'b1, 1'b0, o);
    cyc(1'b0, 1'b0, o);
    cyc(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i], o);
      dout[i] = o;
    end
    cyc(1'b1, 1'b0, o);
    cyc(1'b0, 1'b0, o);
    // the update rise is taken a few clocks after the pin edge
    repeat (6) @(posedge clock);
  endtask
endmodule // ctl_model

// ### scan_checker.sv
// timing checks on the boundary-scan port outputs
// assumes binding to sram_boundary_scan_instr, tck at 8 clocks a period
`timescale 1ns/1ps
module scan_checker #(
  parameter int unsigned BSR_LEN = scan_pkg::BSR_LEN_119
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic mem_out_hiz,
  input wire logic bsr_drive,
  input wire logic [BSR_LEN-1:0] bsr_latched
);
  logic [5:0] hist_q;
  logic rose_w;
  logic fell_w;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) hist_q <= '1;
    else hist_q <= {hist_q[4:0], tck};
  end
  // answers land 3 to 5 clocks after the pin edge, through the synchroniser;
  // a change is legal only while that edge sits inside this window
  assign rose_w = hist_q[2] & ~hist_q[5];
  assign fell_w = ~hist_q[2] & hist_q[5];
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_reset_vals: assert property ($rose(rst_b) |-> !mem_out_hiz &&
    !bsr_drive && !tdo && !tdo_oe && bsr_latched == {1'b1, {(BSR_LEN-1){1'b0}}})
    else $error("outputs not at reset values");
  a_tdo_on_fall: assert property ($changed(tdo) |-> fell_w)
    else $error("tdo moved without tck fall");
  a_oe_on_fall: assert property ($changed(tdo_oe) |-> fell_w)
    else $error("tdo_oe moved without tck fall");
  a_oe_stands: assert property ($rose(tdo_oe) |-> tdo_oe [*6])
    else $error("tdo_oe dropped early");
  a_latch_on_rise: assert property ($changed(bsr_latched) |-> rose_w)
    else $error("latches moved without tck rise");
  a_drive_on_rise: assert property ($changed(bsr_drive) |-> rose_w)
    else $error("drive moved without tck rise");
  a_hiz_on_rise: assert property ($changed(mem_out_hiz) |-> rose_w)
    else $error("hiz moved without tck rise");
  a_ctrl_hiz: assert property (bsr_drive && $stable(bsr_drive) &&
    $stable(bsr_latched) |-> mem_out_hiz == !bsr_latched[BSR_LEN-1])
    else $error("hiz does not follow control cell");
  c_extest_hiz: cover property (bsr_drive && mem_out_hiz);
  c_sample_z: cover property (!bsr_drive && mem_out_hiz);
  c_shift: cover property ($rose(tdo_oe));
endmodule // scan_checker
bind sram_boundary_scan_instr scan_checker #(.BSR_LEN(BSR_LEN)) chk_inst (
  .clock(clock), .rst_b(rst_b), .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe),
  .mem_out_hiz(mem_out_hiz), .bsr_drive(bsr_drive),
  .bsr_latched(bsr_latched));

// ### scan_pkg.sv
// constants and types for the sram boundary-scan test logic
// assumes one test port per device and a single system clock domain
package scan_pkg;

  // instruction register
  localparam int unsigned IR_LEN = 3;
  localparam logic [2:0] INSTR_EXTEST = 3'h0;
  localparam logic [2:0] INSTR_IDCODE = 3'h1;
  localparam logic [2:0] INSTR_SAMPLE_Z = 3'h2;
  localparam logic [2:0] INSTR_PRELOAD = 3'h4;
  localparam logic [2:0] INSTR_BYPASS = 3'h7;
  // fixed pattern loaded in capture-ir, low two bits 01
  localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;
  // instruction after test-logic-reset
  localparam logic [2:0] IR_RESET_VAL = 3'h1;

  // data register lengths
  localparam int unsigned ID_LEN = 32;
  localparam int unsigned BSR_LEN_119 = 85;
  localparam int unsigned BSR_LEN_165 = 89;

  // identification field values (revision, depth, width, present bit)
  localparam logic [2:0] ID_REVISION = 3'h0;
  localparam logic [4:0] ID_DEPTH = 5'h0b;
  localparam logic [5:0] ID_WIDTH = 6'h09;
  localparam logic ID_PRESENT = 1'h1;

  // reset values
  localparam logic TDO_RESET = 1'h0;
  localparam logic CTRL_CELL_PRESET = 1'h1;

  // synchroniser depth for pins sampled from the test port
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_e;

endpackage

// ### sram_boundary_scan_instr.sv
// boundary-scan instruction decode and data register selection
// Contract
// - code 000 captures the io ring, scans boundary cells, tri-states only while the control cell is low.
// - code 001 scans the 32-bit identification value, memory untouched.
// - code 010 captures the io ring, scans boundary cells, tri-states.
// - code 100 captures the io ring and scans boundary cells only.
// - code 111 puts the single bypass bit in the scan path only.
// - the small package variant has exactly 85 boundary cells.
// - the large package variant has 89 cells, the last one internal.
// - cells of unconnected balls read low when captured but pass shifted data on unchanged.
// - the last internal cell of the chain is preset high.
// - under external test the control cell high drives, low tri-states.
// - the control cell is preset high at reset and in test-logic-reset.
// assumes tck, tms and tdi come from an external controller, asynchronous
// to clock, with tck well below a quarter of the clock rate
`timescale 1ns/1ps
module sram_boundary_scan_instr #(
  parameter int unsigned BSR_LEN = scan_pkg::BSR_LEN_119,
  parameter logic [BSR_LEN-2:0] NC_MASK = '0,
  parameter logic [5:0] ID_DEVICE = 6'h2a, // arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h5a6 // arbitrary value
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic [BSR_LEN-2:0] io_ring,
  output logic tdo,
  output logic tdo_oe,
  output logic mem_out_hiz,
  output logic bsr_drive,
  output logic [BSR_LEN-1:0] bsr_latched
);
  import scan_pkg::*;

  localparam logic [ID_LEN-1:0] ID_VALUE =
    {ID_REVISION, ID_DEPTH, ID_WIDTH, ID_DEVICE, ID_MAKER, ID_PRESENT};
  localparam int unsigned TOP = BSR_LEN - 1;

  // pin synchronisers; a third tck stage only feeds edge detection
  logic [SYNC_STAGES:0] tck_q;
  logic [SYNC_STAGES-1:0] tms_q;
  logic [SYNC_STAGES-1:0] tdi_q;
  logic tck_rise;
  logic tck_fall;
  tap_state_e state;

  logic [IR_LEN-1:0] ir_sr_q;
  logic [IR_LEN-1:0] ir_q;
  logic bypass_q;
  logic [ID_LEN-1:0] id_sr_q;
  logic [BSR_LEN-1:0] bsr_q;
  logic [BSR_LEN-1:0] bsr_d;
  logic [BSR_LEN-1:0] bsr_cap;
  logic [BSR_LEN-1:0] latch_q;
  logic tdo_q;
  logic tdo_oe_q;
  logic hiz_q;
  logic drive_q;
  logic sel_bsr;
  logic sel_id;
  logic is_extest;
  logic is_sample_z;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      // idle-high level, so a release does not fake a tck edge
      tck_q <= '1;
      tms_q <= '1;
      tdi_q <= '1;
    end else begin
      tck_q <= {tck_q[SYNC_STAGES-1:0], tck};
      tms_q <= {tms_q[SYNC_STAGES-2:0], tms};
      tdi_q <= {tdi_q[SYNC_STAGES-2:0], tdi};
    end
  end

  assign tck_rise = tck_q[SYNC_STAGES-1] & ~tck_q[SYNC_STAGES];
  assign tck_fall = ~tck_q[SYNC_STAGES-1] & tck_q[SYNC_STAGES];

  tap_fsm u_tap (
    .clock(clock),
    .rst_b(rst_b),
    .tck_rise(tck_rise),
    .tms(tms_q[SYNC_STAGES-1]),
    .state(state)
  );

  // decode of the current instruction; reserved codes fall to bypass
  // so a stray load cannot disturb the memory
  always_comb begin
    is_extest = 1'h0;
    is_sample_z = 1'h0;
    sel_bsr = 1'h0;
    sel_id = 1'h0;
    unique case (ir_q)
      INSTR_EXTEST: begin
        is_extest = 1'h1;
        sel_bsr = 1'h1;
      end
      INSTR_IDCODE: sel_id = 1'h1;
      INSTR_SAMPLE_Z: begin
        is_sample_z = 1'h1;
        sel_bsr = 1'h1;
      end
      INSTR_PRELOAD: sel_bsr = 1'h1;
      default: sel_bsr = 1'h0;
    endcase
  end

  // instruction register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ir_sr_q <= IR_CAPTURE_VAL;
      ir_q <= IR_RESET_VAL;
    end else if (tck_rise) begin
      unique case (state)
        TLR: ir_q <= IR_RESET_VAL;
        CAP_IR: ir_sr_q <= IR_CAPTURE_VAL;
        SHF_IR: ir_sr_q <= {tdi_q[SYNC_STAGES-1], ir_sr_q[IR_LEN-1:1]};
        UPD_IR: ir_q <= ir_sr_q;
        default: ir_q <= ir_q;
      endcase
    end
  end

  // bypass and identification registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bypass_q <= 1'h0;
      id_sr_q <= ID_VALUE;
    end else if (tck_rise && !sel_bsr) begin
      if (state == CAP_DR) begin
        bypass_q <= 1'h0;
        id_sr_q <= ID_VALUE;
      end else if (state == SHF_DR) begin
        bypass_q <= tdi_q[SYNC_STAGES-1];
        id_sr_q <= {tdi_q[SYNC_STAGES-1], id_sr_q[ID_LEN-1:1]};
      end
    end
  end

  // boundary cells: unconnected balls capture low but still pass shifted
  // data on, so the chain stays whole; the control cell captures high
  assign bsr_cap[TOP] = CTRL_CELL_PRESET;
  assign bsr_d[TOP] = tdi_q[SYNC_STAGES-1];
  for (genvar i = 0; i < TOP; i++) begin : g_cell
    assign bsr_cap[i] = io_ring[i] & ~NC_MASK[i];
    assign bsr_d[i] = bsr_q[i+1];
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bsr_q <= '0;
    end else if (tck_rise && sel_bsr) begin
      if (state == CAP_DR) begin
        bsr_q <= bsr_cap;
      end else if (state == SHF_DR) begin
        bsr_q <= bsr_d;
      end
    end
  end

  // latched parallel outputs of the boundary cells
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      latch_q <= {CTRL_CELL_PRESET, {TOP{1'h0}}};
    end else if (tck_rise) begin
      if (state == TLR) begin
        latch_q[TOP] <= CTRL_CELL_PRESET;
      end else if (state == UPD_DR && sel_bsr) begin
        latch_q <= bsr_q;
      end
    end
  end

  // serial output changes on the test-clock fall only
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tdo_q <= TDO_RESET;
      tdo_oe_q <= 1'h0;
    end else if (tck_fall) begin
      tdo_oe_q <= (state == SHF_IR) || (state == SHF_DR);
      if (state == SHF_IR) begin
        tdo_q <= ir_sr_q[0];
      end else if (state == SHF_DR) begin
        if (sel_bsr) begin
          tdo_q <= bsr_q[0];
        end else if (sel_id) begin
          tdo_q <= id_sr_q[0];
        end else begin
          tdo_q <= bypass_q;
        end
      end
    end
  end

  // memory output control: sample-z always tri-states, external test
  // defers to the latched control cell
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hiz_q <= 1'h0;
      drive_q <= 1'h0;
    end else begin
      hiz_q <= is_sample_z
        || (is_extest && !latch_q[TOP]);
      drive_q <= is_extest;
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;
  assign mem_out_hiz = hiz_q;
  assign bsr_drive = drive_q;
  assign bsr_latched = latch_q;

endmodule // sram_boundary_scan_instr

// ### sram_boundary_scan_instr_bench.sv
// self-checking bench for the boundary-scan test logic
// assumes ctl_model plays the controller and the checker is bound
`timescale 1ns/1ps
module sram_boundary_scan_instr_bench;
  import scan_pkg::*;
  typedef logic [89:0] v_t;
  typedef struct {logic [2:0] code; logic hiz; logic drv; int len;
    logic hiz2;} row_s;
  localparam logic [83:0] IO = {21{4'hb}};
  localparam logic [83:0] NC = 84'h9;
  localparam logic [87:0] IO_BIG = {22{4'h6}};
  localparam logic [5:0] DEV = 6'h2a; // arbitrary value
  localparam logic [10:0] MAKER = 11'h5a6; // arbitrary value
  localparam v_t ID = v_t'({ID_REVISION, ID_DEPTH, ID_WIDTH, DEV, MAKER,
    ID_PRESENT});
  localparam v_t PRE = v_t'({1'b1, 84'h0});
  row_s rows [5] = '{
    '{INSTR_EXTEST, 1'b0, 1'b1, 85, 1'b1},
    '{INSTR_IDCODE, 1'b0, 1'b0, 32, 1'b0},
    '{INSTR_SAMPLE_Z, 1'b1, 1'b0, 85, 1'b1},
    '{INSTR_PRELOAD, 1'b0, 1'b0, 85, 1'b0},
    '{INSTR_BYPASS, 1'b0, 1'b0, 1, 1'b0}};
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic big = 1'b0;
  logic tck, tms, tdi, tdo_w, tdo_s, tdo_b, o, tdo_oe, mem_out_hiz, bsr_drive;
  logic [84:0] bsr_latched;
  v_t d, e;
  int bad_count = 0;
  int n_compared = 0;
  always #20 clock = ~clock;
  assign tdo_w = big ? tdo_b : tdo_s;
  ctl_model ctl_model_inst (.clock(clock), .tdo(tdo_w), .tck(tck), .tms(tms),
    .tdi(tdi));
  sram_boundary_scan_instr #(.NC_MASK(NC), .ID_DEVICE(DEV), .ID_MAKER(MAKER))
    sram_boundary_scan_instr_inst (.clock(clock), .rst_b(rst_b), .tck(tck),
    .tms(tms), .tdi(tdi), .io_ring(IO), .tdo(tdo_s), .tdo_oe(tdo_oe),
    .mem_out_hiz(mem_out_hiz), .bsr_drive(bsr_drive),
    .bsr_latched(bsr_latched));
  sram_boundary_scan_instr #(.BSR_LEN(BSR_LEN_165)) big_sram_inst (
    .clock(clock), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
    .io_ring(IO_BIG), .tdo(tdo_b), .tdo_oe(), .mem_out_hiz(), .bsr_drive(),
    .bsr_latched());
  task automatic chk(input v_t seen, input v_t exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #1_000_000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    chk(v_t'(bsr_latched), PRE);
    ctl_model_inst.cyc(1'b0, 1'b0, o);
    foreach (rows[i]) begin
      ctl_model_inst.scan(1'b1, 3, v_t'(rows[i].code), d);
      chk(v_t'(d[2:0]), v_t'(IR_CAPTURE_VAL));
      chk(v_t'({mem_out_hiz, bsr_drive}),
        v_t'({rows[i].hiz, rows[i].drv}));
      e = rows[i].len == 1 ? v_t'(0) : rows[i].len == 32 ? ID :
        v_t'({1'b1, IO & ~NC});
      ctl_model_inst.scan(1'b0, rows[i].len + 1, v_t'(1), d);
      chk(d,
        e | (v_t'(1) << rows[i].len));
      chk(v_t'({mem_out_hiz, bsr_latched}),
        v_t'({rows[i].hiz2, 85'h0}));
    end
    repeat (5) ctl_model_inst.cyc(1'b1, 1'b0, o);
    ctl_model_inst.cyc(1'b0, 1'b0, o);
    repeat (4) @(posedge clock);
    chk(v_t'(bsr_latched), PRE);
    ctl_model_inst.scan(1'b0, 33, v_t'(1), d);
    chk(d, ID | (v_t'(1) << 32));
    ctl_model_inst.scan(1'b1, 3, v_t'(INSTR_PRELOAD), d);
    big <= 1'b1;
    ctl_model_inst.scan(1'b0, 90, v_t'(1), d);
    chk(d, {2'b11, IO_BIG});
    big <= 1'b0;
    ctl_model_inst.scan(1'b1, 3, v_t'(INSTR_EXTEST), d);
    chk(v_t'({mem_out_hiz, bsr_drive}), v_t'(2'b11));
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    chk(v_t'({mem_out_hiz, bsr_drive, tdo_oe, tdo_s, bsr_latched}),
      PRE);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    report_and_stop();
  end
endmodule // sram_boundary_scan_instr_bench

// ### tap_fsm.sv
// test access port state sequencer
// assumes tck_rise is a one-cycle pulse per test-clock rising edge and
// tms has already been synchronised to clock
`timescale 1ns/1ps
module tap_fsm (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic tck_rise,
  input wire logic tms,
  output scan_pkg::tap_state_e state
);
  import scan_pkg::*;

  tap_state_e state_q;
  tap_state_e state_d;

  assign state = state_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      TLR: state_d = tms ? TLR : RTI;
      RTI: state_d = tms ? SEL_DR : RTI;
      SEL_DR: state_d = tms ? SEL_IR : CAP_DR;
      CAP_DR: state_d = tms ? EX1_DR : SHF_DR;
      SHF_DR: state_d = tms ? EX1_DR : SHF_DR;
      EX1_DR: state_d = tms ? UPD_DR : PAU_DR;
      PAU_DR: state_d = tms ? EX2_DR : PAU_DR;
      EX2_DR: state_d = tms ? UPD_DR : SHF_DR;
      UPD_DR: state_d = tms ? SEL_DR : RTI;
      SEL_IR: state_d = tms ? TLR : CAP_IR;
      CAP_IR: state_d = tms ? EX1_IR : SHF_IR;
      SHF_IR: state_d = tms ? EX1_IR : SHF_IR;
      EX1_IR: state_d = tms ? UPD_IR : PAU_IR;
      PAU_IR: state_d = tms ? EX2_IR : PAU_IR;
      EX2_IR: state_d = tms ? UPD_IR : SHF_IR;
      UPD_IR: state_d = tms ? SEL_DR : RTI;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= TLR;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

endmodule // tap_fsm
